/* File: src/error_action_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "error_action_cfg.svh"
// Functional notes
// - Hard power-on: weak set, rest cleared
// - Other reset: copy two bits, then clear
// - Copies land in info bits 33, 32
// - Bit 9 gates uncorrectable restrainable traps
// - Bit 8 gates corrected/degrade restrainable traps
// - Weak off: no suppression of errors
// - Weak on: suppress continuable sync errors
// - Suppressed error leaves unpredictable destination
// - Non-continuable errors always detected, trapped
// - Weak masks autonomous and restrainable traps
// - Nested error with handler sets weak
// - Handler bit says handler is running
// - Handler bit masks asynchronous trap classes
// - Handler bit decides multiple-error trap
// - Async data error trap sets handler
// - Retry or skip return clears handler
module error_action_control
  import error_action_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire reset_kind_t reset_kind,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [63:0] reg_wdata,
  output logic      [63:0] reg_rdata,
  input  wire logic        sync_error_seen,
  input  wire logic        sync_error_can_continue,
  input  wire logic        uncorr_event,
  input  wire logic        corr_degrade_event,
  input  wire logic        autonomous_urgent_error,
  input  wire logic        async_data_error_taken,
  input  wire logic        trap_return_done,
  output logic             sync_error_report,
  output logic             sync_error_suppressed,
  output logic             multiple_error_trap,
  output logic             restrainable_trap,
  output logic             autonomous_trap,
  output logic             fatal_info_capture,
  output logic             fatal_info_weak,
  output logic             fatal_info_handler,
  output logic             weak_detection,
  output logic             urgent_handler_present
);
  logic restrainable_trap_uncorr_submask;
  logic restrainable_trap_corr_degrade_submask;
  logic hit_wr;
  logic g_report;
  logic g_supp;
  logic g_multi;
  logic g_restr;
  logic g_auto;

  // Register select, shared by the write and the read path
  function automatic logic reg_sel(input logic [7:0] addr);
    return addr == `EAC_REG_OFFSET;
  endfunction

  assign hit_wr = reg_wr & reg_sel(reg_addr);

  error_trap_gate u_gate
  (
    .weak_detection                         (weak_detection),
    .urgent_handler_present                 (urgent_handler_present),
    .restrainable_trap_uncorr_submask       (restrainable_trap_uncorr_submask),
    .restrainable_trap_corr_degrade_submask (restrainable_trap_corr_degrade_submask),
    .sync_error_seen                        (sync_error_seen),
    .sync_error_can_continue                (sync_error_can_continue),
    .uncorr_event                           (uncorr_event),
    .corr_degrade_event                     (corr_degrade_event),
    .autonomous_urgent_error                (autonomous_urgent_error),
    .sync_error_report                      (g_report),
    .sync_error_suppressed                  (g_supp),
    .multiple_error_trap                    (g_multi),
    .restrainable_trap                      (g_restr),
    .autonomous_trap                        (g_auto)
  );

  // Weak-detection bit; hardware set wins over a write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      weak_detection <= 1'b0;
    else if (reset_kind == RST_HARD_POR)
      weak_detection <= 1'b1;
    else if (reset_kind == RST_OTHER)
      weak_detection <= 1'b0;
    else if (g_multi)
      weak_detection <= 1'b1;
    else if (hit_wr)
      weak_detection <= reg_wdata[`EAC_BIT_WEAK];
  end

  // Handler bit; trap entry outranks return, both outrank writes
  always_ff @(posedge clk)
  begin
    if (sys_rst || reset_kind != RST_NONE)
      urgent_handler_present <= 1'b0;
    else if (async_data_error_taken)
      urgent_handler_present <= 1'b1;
    else if (trap_return_done)
      urgent_handler_present <= 1'b0;
    else if (hit_wr)
      urgent_handler_present <= reg_wdata[`EAC_BIT_HANDLER];
  end

  // Submasks are software-only
  always_ff @(posedge clk)
  begin
    if (sys_rst || reset_kind != RST_NONE)
    begin
      restrainable_trap_uncorr_submask       <= 1'b0;
      restrainable_trap_corr_degrade_submask <= 1'b0;
    end
    else if (hit_wr)
    begin
      restrainable_trap_uncorr_submask       <= reg_wdata[`EAC_BIT_UNCORR];
      restrainable_trap_corr_degrade_submask <= reg_wdata[`EAC_BIT_CORR_DG];
    end
  end

  // Copy into fatal-info uses pre-reset values, so it is taken first
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fatal_info_capture <= 1'b0;
      fatal_info_weak    <= 1'b0;
      fatal_info_handler <= 1'b0;
    end
    else
    begin
      fatal_info_capture <= (reset_kind == RST_OTHER);
      if (reset_kind == RST_OTHER)
      begin
        fatal_info_weak    <= weak_detection;
        fatal_info_handler <= urgent_handler_present;
      end
    end
  end

  // Registered read; unused bits stay zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 64'h0;
    else if (reg_rd && reg_sel(reg_addr))
    begin
      reg_rdata <= 64'h0;
      reg_rdata[`EAC_BIT_WEAK]    <= weak_detection;
      reg_rdata[`EAC_BIT_HANDLER] <= urgent_handler_present;
      reg_rdata[`EAC_BIT_UNCORR]  <= restrainable_trap_uncorr_submask;
      reg_rdata[`EAC_BIT_CORR_DG] <= restrainable_trap_corr_degrade_submask;
    end
    else
      reg_rdata <= 64'h0;
  end

  // Trap decisions registered so outputs come from flops
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync_error_report     <= 1'b0;
      sync_error_suppressed <= 1'b0;
      multiple_error_trap   <= 1'b0;
      restrainable_trap     <= 1'b0;
      autonomous_trap       <= 1'b0;
    end
    else
    begin
      sync_error_report     <= g_report;
      sync_error_suppressed <= g_supp;
      multiple_error_trap   <= g_multi;
      restrainable_trap     <= g_restr;
      autonomous_trap       <= g_auto;
    end
  end

  AST_HARD_POR: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_HARD_POR |=> weak_detection && !urgent_handler_present)
    else $error("hard reset value wrong");
  AST_OTHER_CLR: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_OTHER |=> !weak_detection && !urgent_handler_present)
    else $error("other reset did not clear");
  AST_COPY: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_OTHER |=> fatal_info_capture
      && fatal_info_weak == $past(weak_detection)
      && fatal_info_handler == $past(urgent_handler_present))
    else $error("fatal info copy wrong");
  AST_MULTI_WEAK: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_NONE && sync_error_seen && !(weak_detection && sync_error_can_continue)
      && urgent_handler_present |=> multiple_error_trap && weak_detection)
    else $error("multiple error trap missed");
  AST_SUPPRESS: assert property (@(posedge clk) disable iff (sys_rst)
    sync_error_seen && weak_detection && sync_error_can_continue |=> !sync_error_report)
    else $error("suppression failed");
  AST_NO_SUPP: assert property (@(posedge clk) disable iff (sys_rst)
    sync_error_seen && !weak_detection |=> sync_error_report)
    else $error("error not reported");
  AST_MASK: assert property (@(posedge clk) disable iff (sys_rst)
    (weak_detection || urgent_handler_present) |=> !restrainable_trap && !autonomous_trap)
    else $error("masked trap leaked");
  AST_HANDLER_SET: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_NONE && async_data_error_taken |=> urgent_handler_present)
    else $error("handler not set");
  AST_HANDLER_CLR: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_NONE && !async_data_error_taken && trap_return_done
      |=> !urgent_handler_present)
    else $error("handler not cleared");

  // Other reset is two steps: copy out with clear, then the pulse drops
  sequence seq_other_req;
    reset_kind == RST_OTHER ##1 reset_kind == RST_NONE;
  endsequence
  sequence seq_copied_and_cleared;
    fatal_info_capture && !weak_detection && !urgent_handler_present
      && !restrainable_trap_uncorr_submask && !restrainable_trap_corr_degrade_submask;
  endsequence
  sequence seq_capture_ends;
    !fatal_info_capture;
  endsequence

  AST_OTHER_SEQ: assert property (@(posedge clk) disable iff (sys_rst)
    seq_other_req |-> seq_copied_and_cleared ##1 seq_capture_ends)
    else $error("other reset sequence wrong");
  AST_RESET_SUBMASK: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind != RST_NONE |=> !restrainable_trap_uncorr_submask
      && !restrainable_trap_corr_degrade_submask)
    else $error("reset left a submask set");
  AST_NO_MULTI: assert property (@(posedge clk) disable iff (sys_rst)
    !urgent_handler_present |=> !multiple_error_trap)
    else $error("multiple error trap without handler");
  AST_SUBMASK_WR: assert property (@(posedge clk) disable iff (sys_rst)
    reset_kind == RST_NONE && hit_wr && reg_wdata[`EAC_BIT_UNCORR]
      && !reg_wdata[`EAC_BIT_CORR_DG]
      |=> restrainable_trap_uncorr_submask && !restrainable_trap_corr_degrade_submask)
    else $error("submask write lost");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rdata[`EAC_WIDTH-1:`EAC_BIT_UNCORR+1] == '0
      && reg_rdata[`EAC_BIT_CORR_DG-1:`EAC_BIT_WEAK+1] == '0)
    else $error("reserved read bits set");
endmodule
`default_nettype wire

/* File: shared/error_action_cfg.svh */
`ifndef ERROR_ACTION_CFG_SVH
`define ERROR_ACTION_CFG_SVH
`define EAC_REG_OFFSET     8'h10
`define EAC_BIT_HANDLER    0
`define EAC_BIT_WEAK       1
`define EAC_BIT_CORR_DG    8
`define EAC_BIT_UNCORR     9
`define FEI_BIT_HANDLER    32
`define FEI_BIT_WEAK       33
`define EAC_WIDTH          64
`endif

/* File: shared/error_action_pkg.sv */
package error_action_pkg;
  // Kind of reset seen by the core
  typedef enum logic [1:0] {
    RST_NONE,
    RST_HARD_POR,
    RST_OTHER
  } reset_kind_t;
endpackage

/* File: src/error_trap_gate.sv */
`timescale 1ns/1ps
`default_nettype none
`include "error_action_cfg.svh"
module error_trap_gate
(
  input  wire logic weak_detection,
  input  wire logic urgent_handler_present,
  input  wire logic restrainable_trap_uncorr_submask,
  input  wire logic restrainable_trap_corr_degrade_submask,
  input  wire logic sync_error_seen,
  input  wire logic sync_error_can_continue,
  input  wire logic uncorr_event,
  input  wire logic corr_degrade_event,
  input  wire logic autonomous_urgent_error,
  output logic      sync_error_report,
  output logic      sync_error_suppressed,
  output logic      multiple_error_trap,
  output logic      restrainable_trap,
  output logic      autonomous_trap
);
  // Weak detection hides only errors the pipe can ride through
  assign sync_error_suppressed = sync_error_seen & weak_detection & sync_error_can_continue;
  assign sync_error_report = sync_error_seen & ~sync_error_suppressed;
  // Nested error while a handler already runs
  assign multiple_error_trap = sync_error_report & urgent_handler_present;
  // Both control bits mask the asynchronous trap classes
  assign autonomous_trap = autonomous_urgent_error & ~weak_detection & ~urgent_handler_present;
  assign restrainable_trap = ~weak_detection & ~urgent_handler_present &
    ((uncorr_event & restrainable_trap_uncorr_submask) |
     (corr_degrade_event & restrainable_trap_corr_degrade_submask));
endmodule
`default_nettype wire

/* File: verif/error_action_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module error_action_control_tb
  import error_action_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  reset_kind_t reset_kind;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [63:0] reg_wdata;
  logic [63:0] reg_rdata;
  logic [6:0]  ev_in;
  logic [6:0]  dec;
  logic        cap;
  logic        fi_weak;
  logic        fi_hnd;
  logic [1:0]  bits;
  logic        rd_d;
  logic [63:0] exp_q[$];
  logic [63:0] r;
  int          fail_count;
  int          tests_run;

  error_action_control dut_u (.clk(clk), .sys_rst(sys_rst), .reset_kind(reset_kind),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sync_error_seen(ev_in[6]), .sync_error_can_continue(ev_in[5]),
    .uncorr_event(ev_in[4]), .corr_degrade_event(ev_in[3]),
    .autonomous_urgent_error(ev_in[2]), .async_data_error_taken(ev_in[1]),
    .trap_return_done(ev_in[0]), .sync_error_report(dec[4]),
    .sync_error_suppressed(dec[3]), .multiple_error_trap(dec[2]),
    .restrainable_trap(dec[1]), .autonomous_trap(dec[0]), .fatal_info_capture(cap),
    .fatal_info_weak(fi_weak), .fatal_info_handler(fi_hnd), .weak_detection(bits[1]),
    .urgent_handler_present(bits[0]));

  // Free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Read data is one cycle after the request; oldest note is matched
  always @(posedge clk)
  begin
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end

  task automatic wr(input logic [7:0] a, input logic [63:0] d, input logic [6:0] e);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    ev_in <= e;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Leave the event lines to the next task unless this write raised one
    if (e != 7'h00)
      ev_in <= 7'h00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [63:0] e);
    exp_q.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle event; decisions are sampled one edge later
  task automatic ev(input logic [6:0] v, input logic [4:0] want);
    ev_in <= v;
    @(posedge clk);
    ev_in <= 7'h00;
    @(posedge clk);
    chk({59'h0, dec[4:0]}, {59'h0, want});
  endtask

  task automatic rst_kind(input reset_kind_t k);
    reset_kind <= k;
    @(posedge clk);
    reset_kind <= RST_NONE;
    @(posedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    $display("BAD %0t run did not finish", $time);
    conclude();
  end

  initial
  begin
    {sys_rst, reg_wr, reg_rd, ev_in} = 10'h200;
    {reg_addr, reg_wdata} = 72'h0;
    reset_kind = RST_NONE;
    fail_count = 0;
    tests_run = 0;
    r = $urandom(71251);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rst_kind(RST_HARD_POR);
    rd(8'h10, 64'h2);
    for (int i = 0; i < 6; i++)
    begin
      r = {$urandom, $urandom};
      wr(8'h10, r, 7'h00);
      rd(8'h10, r & 64'h303);
      wr(8'h20, ~r, 7'h00);
      rd(8'h20, 64'h0);
    end
    // Weak and handler differ so a swapped copy shows
    wr(8'h10, 64'h302, 7'h00);
    reset_kind <= RST_OTHER;
    @(posedge clk);
    reset_kind <= RST_NONE;
    @(posedge clk);
    chk({61'h0, cap, fi_weak, fi_hnd}, 64'h6);
    @(posedge clk);
    chk({61'h0, cap, fi_weak, fi_hnd}, 64'h2);
    rd(8'h10, 64'h0);
    wr(8'h10, 64'h300, 7'h00);
    ev(7'h10, 5'h02);
    ev(7'h08, 5'h02);
    // One submask on, the other off: each gates only its own class
    wr(8'h10, 64'h200, 7'h00);
    ev(7'h08, 5'h00);
    ev(7'h10, 5'h02);
    ev(7'h04, 5'h01);
    ev(7'h60, 5'h10);
    wr(8'h10, 64'h302, 7'h00);
    ev(7'h18, 5'h00);
    ev(7'h60, 5'h08);
    ev(7'h40, 5'h10);
    wr(8'h10, 64'h300, 7'h00);
    ev(7'h02, 5'h00);
    chk({62'h0, bits}, 64'h1);
    ev(7'h10, 5'h00);
    ev(7'h40, 5'h14);
    rd(8'h10, 64'h303);
    ev(7'h01, 5'h00);
    rd(8'h10, 64'h302);
    wr(8'h10, 64'h0, 7'h02);
    @(posedge clk);
    rd(8'h10, 64'h1);
    // Hard power-on from a busy state must still clear the submasks
    wr(8'h10, 64'h303, 7'h00);
    rst_kind(RST_HARD_POR);
    rd(8'h10, 64'h2);
    repeat (2) @(posedge clk);
    chk({63'h0, exp_q.size() == 0}, 64'h1);
    conclude();
  end
endmodule
`default_nettype wire
